// [hdl/cefa_axil.sv]
/*
  AXI4-Lite slave for the two endpoint buffer registers.
  Assumes the owner supplies both read values from flip-flops and acts on
  the one-cycle write pulse with its byte mask.
*/
`timescale 1ns/100ps
`include "cefa_params.svh"

module cefa_axil
  import cefa_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Write address and data
  input  wire logic [`CEFA_ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // Write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // Read address and data
  input  wire logic [`CEFA_ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // Register side
  input  wire logic [15:0]             sel_rd,
  input  wire logic [15:0]             ctl_rd,
  output logic                         wr_sel,
  output logic                         wr_ctl,
  output logic [15:0]                  wr_data,
  output logic [15:0]                  wr_mask
);

  typedef struct packed {
    cefa_bus_t               state;
    logic                    aw_got;
    logic                    w_got;
    logic [`CEFA_ADDR_W-1:0] addr;
    logic [15:0]             data;
    logic [1:0]              strb;
    logic                    awready;
    logic                    wready;
    logic                    arready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [15:0]             rdata;
    logic [1:0]              rresp;
    logic                    wr_sel;
    logic                    wr_ctl;
  } cefa_axil_st_t;

  cefa_axil_st_t q_ff;
  cefa_axil_st_t nxt_q;

  always_comb begin
    nxt_q        = q_ff;
    nxt_q.wr_sel = 1'b0;
    nxt_q.wr_ctl = 1'b0;
    case (q_ff.state)
      CEFA_BUS_IDLE: begin
        if (awvalid && q_ff.awready) begin
          nxt_q.addr    = awaddr;
          nxt_q.aw_got  = 1'b1;
          nxt_q.awready = 1'b0;
        end
        if (wvalid && q_ff.wready) begin
          nxt_q.data   = wdata[15:0];
          nxt_q.strb   = wstrb[1:0];
          nxt_q.w_got  = 1'b1;
          nxt_q.wready = 1'b0;
        end
        if (arvalid && q_ff.arready) begin
          // Read taken first; a write caught alongside waits for it
          nxt_q.arready = 1'b0;
          nxt_q.awready = 1'b0;
          nxt_q.wready  = 1'b0;
          nxt_q.rvalid  = 1'b1;
          nxt_q.state   = CEFA_BUS_RRSP;
          if (araddr == `CEFA_SEL_ADDR) begin
            nxt_q.rdata = sel_rd;
            nxt_q.rresp = `CEFA_RESP_OKAY;
          end else if (araddr == `CEFA_CTL_ADDR) begin
            nxt_q.rdata = ctl_rd;
            nxt_q.rresp = `CEFA_RESP_OKAY;
          end else begin
            nxt_q.rdata = 16'h0000;
            nxt_q.rresp = `CEFA_RESP_SLVERR;
          end
        end else if (q_ff.aw_got && q_ff.w_got) begin
          nxt_q.arready = 1'b0;
          nxt_q.bvalid  = 1'b1;
          nxt_q.state   = CEFA_BUS_WRSP;
          nxt_q.wr_sel  = (q_ff.addr == `CEFA_SEL_ADDR);
          nxt_q.wr_ctl  = (q_ff.addr == `CEFA_CTL_ADDR);
          nxt_q.bresp   = ((q_ff.addr == `CEFA_SEL_ADDR) || (q_ff.addr == `CEFA_CTL_ADDR))
                          ? `CEFA_RESP_OKAY : `CEFA_RESP_SLVERR;
        end else begin
          nxt_q.arready = ~nxt_q.aw_got & ~nxt_q.w_got;
        end
      end
      CEFA_BUS_WRSP: begin
        if (bready) begin
          nxt_q.bvalid  = 1'b0;
          nxt_q.aw_got  = 1'b0;
          nxt_q.w_got   = 1'b0;
          nxt_q.awready = 1'b1;
          nxt_q.wready  = 1'b1;
          nxt_q.arready = 1'b1;
          nxt_q.state   = CEFA_BUS_IDLE;
        end
      end
      CEFA_BUS_RRSP: begin
        if (rready) begin
          nxt_q.rvalid  = 1'b0;
          nxt_q.awready = ~q_ff.aw_got;
          nxt_q.wready  = ~q_ff.w_got;
          nxt_q.arready = ~q_ff.aw_got & ~q_ff.w_got;
          nxt_q.state   = CEFA_BUS_IDLE;
        end
      end
      default: begin
        nxt_q = '0;
        nxt_q.state = CEFA_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_ff         <= '0;
      q_ff.state   <= CEFA_BUS_IDLE;
      q_ff.awready <= 1'b1;
      q_ff.wready  <= 1'b1;
      q_ff.arready <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign awready = q_ff.awready;
  assign wready  = q_ff.wready;
  assign arready = q_ff.arready;
  assign bvalid  = q_ff.bvalid;
  assign bresp   = q_ff.bresp;
  assign rvalid  = q_ff.rvalid;
  assign rdata   = {16'h0000, q_ff.rdata};
  assign rresp   = q_ff.rresp;
  assign wr_sel  = q_ff.wr_sel;
  assign wr_ctl  = q_ff.wr_ctl;
  assign wr_data = q_ff.data;
  assign wr_mask = {{8{q_ff.strb[1]}}, {8{q_ff.strb[0]}}};

endmodule // cefa_axil

// [hdl/cefa_top.sv]
/*
  Control endpoint buffer access: direction, port width, byte order,
  received length, response handshake, buffer valid, buffer clear,
  access-ready flag and status completion for endpoint 0.
  Assumes the buffer and serial engine report their events as one-cycle
  pulses synchronous to MCLK and act on the pulses and levels given here.
*/
// Notes on behaviour
// R1 - Count mode 0: length holds during reads, clears once all data read.
// R2 - Count mode 1: length drops per read, one in 8-bit, two in 16-bit.
// R3 - Width bit 0 gives 16-bit port; 1 gives 8-bit, upper byte invalid.
// R4 - Width pin forcing 8-bit overrides width bit, which then reads 0.
// R5 - Software sets width before receive; not changed while ready flag is 1.
// R6 - Swap 0: even byte low, odd byte high; swap 1 exchanges them.
// R7 - Software never sets byte swap while the port is 8 bits wide.
// R8 - Direction 0 selects control-write buffer, 1 the control-read buffer.
// R9 - Handshake 00 NAK, 01 by buffer state, 1x STALL.
// R10 - Write direction: valid shows readable data; writes to it ignored.
// R11 - Read direction: valid shows write done; writing 1 forces short packet.
// R12 - Writing 1 to clear empties the CPU-side buffer per direction; 0 nothing. Code: a valid read-direction buffer pulses the SIE-side clear instead.
// R13 - Software sets NAK before clearing a valid read-direction buffer.
// R14 - Ready flag reads 1 while port and fields are inaccessible; resets 1.
// R15 - Completion 0 answers NAK at status; 1 completes status normally.
// R16 - Length field bits 8 to 0 hold bytes received in control write.
// R17 - Software writes zero to all reserved bits of both registers.
// R18 - Write direction: valid sets when reception into the buffer completes.
// R19 - Setup token clears the completion bit.
// R20 - Setup token forces the handshake field to NAK.
// R21 - Both 16-bit registers reachable at fixed addresses over the bus.
`timescale 1ns/100ps
`include "cefa_params.svh"

module cefa_top
  import cefa_pkg::*;
(
  // Clock and reset
  input  wire logic                    MCLK,
  input  wire logic                    RSTN,
  // AXI4-Lite write
  input  wire logic [`CEFA_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output logic                         S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output logic                         S_AXI_WREADY,
  output logic [1:0]                   S_AXI_BRESP,
  output logic                         S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [`CEFA_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output logic                         S_AXI_ARREADY,
  output logic [31:0]                  S_AXI_RDATA,
  output logic [1:0]                   S_AXI_RRESP,
  output logic                         S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY,
  // Strap
  input  wire logic                    WIDTH_SELECT_PIN,
  // Buffer and serial engine events and levels
  input  wire logic                    SETUP_RX,
  input  wire logic                    RX_DONE,
  input  wire logic [8:0]              RX_LEN,
  input  wire logic                    TX_WR_DONE,
  input  wire logic                    TX_DONE,
  input  wire logic                    BUF_BUSY,
  input  wire logic                    DPORT_RD,
  input  wire logic [15:0]             BUF_WORD,
  // Data port lanes
  output logic [15:0]                  DPORT_WORD,
  // Controls to buffer and serial engine
  output logic                         DIR_SEL,
  output logic                         PORT_8BIT,
  output logic [2:0]                   DATA_ANSWER,
  output logic [2:0]                   STATUS_ANSWER,
  output logic                         FORCE_SHORT,
  output logic                         CLR_CPU_BUF,
  output logic                         CLR_SIE_BUF
);

  typedef struct packed {
    logic                  read_count_mode;
    logic                  port_8bit_bit;
    logic                  byte_swap;
    logic                  direction_select;
    cefa_hs_t              response_handshake;
    logic                  buffer_valid;
    logic                  access_ready_flag;
    logic                  status_completion;
    logic [`CEFA_LEN_W-1:0] received_length;
    logic [`CEFA_LEN_W-1:0] remaining;
    logic                  port_8bit;
    logic [15:0]           dport_word;
    cefa_ans_t             data_answer;
    cefa_ans_t             status_answer;
    logic                  force_short;
    logic                  clr_cpu;
    logic                  clr_sie;
  } cefa_top_st_t;

  cefa_top_st_t q_ff;
  cefa_top_st_t nxt_q;

  logic                   wr_sel;
  logic                   wr_ctl;
  logic [15:0]            wr_data;
  logic [15:0]            wr_mask;
  logic [15:0]            sel_rd;
  logic [15:0]            ctl_rd;
  logic                   eff_8bit;
  logic [`CEFA_LEN_W-1:0] step;

  cefa_axil u_axil (
    .clk     (MCLK),
    .rst_n   (RSTN),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .sel_rd  (sel_rd),
    .ctl_rd  (ctl_rd),
    .wr_sel  (wr_sel),
    .wr_ctl  (wr_ctl),
    .wr_data (wr_data),
    .wr_mask (wr_mask)
  );

  // Pin overrides the width bit
  assign eff_8bit = WIDTH_SELECT_PIN | q_ff.port_8bit_bit; // [R3] [R4]
  assign step     = eff_8bit ? `CEFA_STEP_8BIT : `CEFA_STEP_16BIT;

  // Read views; reserved and clear bits read as zero
  always_comb begin
    sel_rd                   = 16'h0000;
    sel_rd[`CEFA_SEL_READ_COUNT_MODE]   = q_ff.read_count_mode;
    sel_rd[`CEFA_SEL_OCTL]   = q_ff.port_8bit_bit & ~WIDTH_SELECT_PIN; // [R4]
    sel_rd[`CEFA_SEL_SWAP]   = q_ff.byte_swap;
    sel_rd[`CEFA_SEL_DIR]    = q_ff.direction_select;
    ctl_rd                   = 16'h0000;
    ctl_rd[`CEFA_CTL_PID_HI:`CEFA_CTL_PID_LO] = q_ff.response_handshake;
    ctl_rd[`CEFA_CTL_VALID]  = q_ff.buffer_valid;
    ctl_rd[`CEFA_CTL_RDY]    = q_ff.access_ready_flag;
    ctl_rd[`CEFA_CTL_STATUS_COMPLETION]   = q_ff.status_completion;
    ctl_rd[`CEFA_CTL_LEN_HI:0] = q_ff.received_length; // [R16]
  end

  always_comb begin
    nxt_q             = q_ff;
    nxt_q.force_short = 1'b0;
    nxt_q.clr_cpu     = 1'b0;
    nxt_q.clr_sie     = 1'b0;

    // Select register writes, per byte lane
    if (wr_sel) begin // [R21]
      if (wr_mask[`CEFA_SEL_READ_COUNT_MODE]) begin
        nxt_q.read_count_mode = wr_data[`CEFA_SEL_READ_COUNT_MODE];
      end
      if (wr_mask[`CEFA_SEL_OCTL]) begin
        nxt_q.port_8bit_bit = wr_data[`CEFA_SEL_OCTL]; // [R3]
      end
      if (wr_mask[`CEFA_SEL_SWAP]) begin
        nxt_q.byte_swap = wr_data[`CEFA_SEL_SWAP]; // [R6]
      end
      if (wr_mask[`CEFA_SEL_DIR]) begin
        nxt_q.direction_select = wr_data[`CEFA_SEL_DIR]; // [R8]
      end
    end

    // Control register writes
    if (wr_ctl) begin // [R21]
      if (wr_mask[`CEFA_CTL_PID_HI]) begin
        nxt_q.response_handshake =
          cefa_hs_t'(wr_data[`CEFA_CTL_PID_HI:`CEFA_CTL_PID_LO]);
      end
      if (wr_mask[`CEFA_CTL_STATUS_COMPLETION]) begin
        nxt_q.status_completion = wr_data[`CEFA_CTL_STATUS_COMPLETION];
      end
      if (wr_mask[`CEFA_CTL_VALID] && q_ff.direction_select) begin
        // Clear runs first so a joint write leaves an empty, completed buffer
        if (wr_data[`CEFA_CTL_BUFFER_CLEAR]) begin // [R12]
          if (q_ff.buffer_valid) begin
            nxt_q.clr_sie      = 1'b1;
            nxt_q.buffer_valid = 1'b0;
          end else begin
            nxt_q.clr_cpu = 1'b1;
          end
        end
        if (wr_data[`CEFA_CTL_VALID]) begin // [R11]
          nxt_q.buffer_valid = 1'b1;
          nxt_q.force_short  = 1'b1;
        end
      end else if (wr_mask[`CEFA_CTL_VALID] && wr_data[`CEFA_CTL_BUFFER_CLEAR]
                   && q_ff.buffer_valid) begin
        // Write direction: valid bit itself ignores writes
        nxt_q.clr_cpu         = 1'b1; // [R10] [R12]
        nxt_q.buffer_valid    = 1'b0;
        nxt_q.received_length = '0;
        nxt_q.remaining       = '0;
      end
    end

    // Data port reads in the write direction
    if (DPORT_RD && !q_ff.direction_select && q_ff.buffer_valid) begin
      if (q_ff.remaining > step) begin
        nxt_q.remaining = q_ff.remaining - step;
        if (q_ff.read_count_mode) begin
          nxt_q.received_length = q_ff.received_length - step; // [R2]
        end
      end else begin
        // Last data read out
        nxt_q.remaining       = '0;
        nxt_q.received_length = '0; // [R1] [R2]
        nxt_q.buffer_valid    = 1'b0;
      end
    end

    // Transmit side events in the read direction
    if (q_ff.direction_select && TX_DONE) begin
      nxt_q.buffer_valid = 1'b0;
    end
    if (q_ff.direction_select && TX_WR_DONE) begin
      nxt_q.buffer_valid = 1'b1; // [R11]
    end

    // Reception complete wins over any clear in the same cycle
    if (!q_ff.direction_select && RX_DONE) begin
      nxt_q.buffer_valid    = 1'b1; // [R18]
      nxt_q.received_length = RX_LEN; // [R16]
      nxt_q.remaining       = RX_LEN;
    end

    // Setup token overrides software
    if (SETUP_RX) begin
      nxt_q.status_completion  = 1'b0; // [R19]
      nxt_q.response_handshake = CEFA_HS_NAK; // [R20]
    end

    nxt_q.access_ready_flag = BUF_BUSY; // [R14]
    nxt_q.port_8bit         = eff_8bit; // [R3] [R4]

    // Lane steering of the buffer word
    if (eff_8bit) begin
      nxt_q.dport_word = {8'h00, BUF_WORD[7:0]}; // [R3]
    end else if (q_ff.byte_swap) begin
      nxt_q.dport_word = {BUF_WORD[7:0], BUF_WORD[15:8]}; // [R6]
    end else begin
      nxt_q.dport_word = BUF_WORD; // [R6]
    end

    // Stage answers
    case (nxt_q.response_handshake)
      CEFA_HS_NAK: begin
        nxt_q.data_answer   = CEFA_ANS_NAK; // [R9]
        nxt_q.status_answer = CEFA_ANS_NAK;
      end
      CEFA_HS_BUF: begin
        nxt_q.data_answer   = CEFA_ANS_DONE; // [R9]
        nxt_q.status_answer = nxt_q.status_completion
                              ? CEFA_ANS_DONE : CEFA_ANS_NAK; // [R15]
      end
      default: begin
        nxt_q.data_answer   = CEFA_ANS_STALL; // [R9]
        nxt_q.status_answer = CEFA_ANS_STALL;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      q_ff                   <= '0;
      q_ff.access_ready_flag <= `CEFA_RST_RDY; // [R14]
      q_ff.data_answer       <= CEFA_ANS_NAK;
      q_ff.status_answer     <= CEFA_ANS_NAK;
      q_ff.port_8bit         <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign DPORT_WORD    = q_ff.dport_word;
  assign DIR_SEL       = q_ff.direction_select;
  assign PORT_8BIT     = q_ff.port_8bit;
  assign DATA_ANSWER   = q_ff.data_answer;
  assign STATUS_ANSWER = q_ff.status_answer;
  assign FORCE_SHORT   = q_ff.force_short;
  assign CLR_CPU_BUF   = q_ff.clr_cpu;
  assign CLR_SIE_BUF   = q_ff.clr_sie;

endmodule // cefa_top

// [include/cefa_params.svh]
/*
  Offsets, field positions, reset values and bus constants of the control
  endpoint buffer access block.
  Assumes inclusion by bare name from design files that need these values.
*/
`ifndef CEFA_PARAMS_SVH
`define CEFA_PARAMS_SVH

// Register indices and byte addresses (four bytes per index)
`define CEFA_SEL_INDEX     8'h30
`define CEFA_CTL_INDEX     8'h32
`define CEFA_SEL_ADDR      8'hC0
`define CEFA_CTL_ADDR      8'hC8
`define CEFA_ADDR_W        8

// Buffer select register fields
`define CEFA_SEL_READ_COUNT_MODE      15
`define CEFA_SEL_OCTL      10
`define CEFA_SEL_SWAP      7
`define CEFA_SEL_DIR       0

// Buffer control register fields
`define CEFA_CTL_PID_HI    15
`define CEFA_CTL_PID_LO    14
`define CEFA_CTL_VALID     13
`define CEFA_CTL_BUFFER_CLEAR      12
`define CEFA_CTL_RDY       11
`define CEFA_CTL_STATUS_COMPLETION      10
`define CEFA_CTL_LEN_HI    8

// Reset values
`define CEFA_SEL_RESET     16'h0000
`define CEFA_CTL_RESET     16'h0800
`define CEFA_RST_RDY       1'b1

// Received length width and port steps
`define CEFA_LEN_W         9
`define CEFA_STEP_8BIT     9'h001
`define CEFA_STEP_16BIT    9'h002

// AXI responses
`define CEFA_RESP_OKAY     2'h0
`define CEFA_RESP_SLVERR   2'h2

`endif

// [include/cefa_pkg.sv]
/*
  Types of the control endpoint buffer access block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cefa_pkg;

  // Response handshake codes
  typedef enum logic [1:0] {
    CEFA_HS_NAK   = 2'h0,
    CEFA_HS_BUF   = 2'h1,
    CEFA_HS_STALL = 2'h2,
    CEFA_HS_STL2  = 2'h3
  } cefa_hs_t;

  // Answer given to the host at a stage
  typedef enum logic [2:0] {
    CEFA_ANS_NAK   = 3'h1,
    CEFA_ANS_DONE  = 3'h2,
    CEFA_ANS_STALL = 3'h4
  } cefa_ans_t;

  // Register bus slave states
  typedef enum logic [2:0] {
    CEFA_BUS_IDLE = 3'h1,
    CEFA_BUS_WRSP = 3'h2,
    CEFA_BUS_RRSP = 3'h4
  } cefa_bus_t;

endpackage

// [sim/cefa_properties.sv]
/*
  Port checks of the endpoint buffer access block.
  Assumes one clock MCLK and the synchronous low reset RSTN.
*/
`timescale 1ns/100ps
`include "cefa_params.svh"

module cefa_properties (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RSTN,
  // Register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  // Block side
  input wire logic        WIDTH_SELECT_PIN,
  input wire logic        SETUP_RX,
  input wire logic [15:0] DPORT_WORD,
  input wire logic        PORT_8BIT,
  input wire logic [2:0]  DATA_ANSWER,
  input wire logic [2:0]  STATUS_ANSWER,
  input wire logic        FORCE_SHORT
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  bvalid_hold_a:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
  write_answer_a:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##[2:20] S_AXI_BVALID) else $error("no write response");
  read_answer_a:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
      && S_AXI_RDATA[31:16] == 16'h0000) else $error("bad read answer");
  unmapped_rd_a:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:6] != 2'h3
      |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read");
  setup_nak_a:
    assert property (SETUP_RX |=> DATA_ANSWER == 3'h1 && STATUS_ANSWER == 3'h1)
      else $error("setup not NAK");
  answer_code_a:
    assert property ($onehot(DATA_ANSWER) && $onehot(STATUS_ANSWER)) else $error("answer code");
  pin_forces_a:
    assert property (WIDTH_SELECT_PIN |=> PORT_8BIT) else $error("pin ignored");
  upper_lane_a:
    assert property (WIDTH_SELECT_PIN && $past(WIDTH_SELECT_PIN) |=> DPORT_WORD[15:8] == 8'h00)
      else $error("upper lane live");
  short_pulse_a:
    assert property (FORCE_SHORT |=> !FORCE_SHORT) else $error("short pulse long");
endmodule // cefa_properties

bind cefa_top cefa_properties u_chk (.*);

// [sim/cefa_sie_model.sv]
/*
  Behavioural serial engine and buffer: event pulses and buffer levels.
  Assumes its tasks are called right after a rising edge of MCLK.
*/
`timescale 1ns/100ps

module cefa_sie_model (
  // Clock
  input wire logic    MCLK,
  // Events
  output logic        SETUP_RX,
  output logic        RX_DONE,
  output logic [8:0]  RX_LEN,
  output logic        TX_WR_DONE,
  output logic        TX_DONE,
  output logic        DPORT_RD,
  // Levels
  output logic        BUF_BUSY,
  output logic [15:0] BUF_WORD
);
  initial begin
    {SETUP_RX, RX_DONE, TX_WR_DONE, TX_DONE, DPORT_RD} = 5'h00;
    RX_LEN = 9'h000;
    BUF_BUSY = 1'b1;
    BUF_WORD = 16'hA55A;
  end

  // Event 0 setup, 1 receive, 2 write done, 3 sent, 4 port read
  task automatic pulse(input int k, input logic [8:0] n);
    @(posedge MCLK);
    {SETUP_RX, RX_DONE, TX_WR_DONE, TX_DONE, DPORT_RD} <= 5'h10 >> k;
    RX_LEN <= n;
    @(posedge MCLK);
    {SETUP_RX, RX_DONE, TX_WR_DONE, TX_DONE, DPORT_RD} <= 5'h00;
    // Length is stale outside its pulse
    RX_LEN <= ~n;
  endtask

  task automatic levels(input logic b, input logic [15:0] w);
    @(posedge MCLK);
    BUF_BUSY <= b;
    BUF_WORD <= w;
  endtask
endmodule // cefa_sie_model

// [sim/ctrl_endpoint_fifo_access_bench.sv]
/*
  Self-checking bench of the endpoint buffer access block.
  Assumes cefa_top, its bound checker and the engine model cefa_sie_model.
*/
`timescale 1ns/100ps
`include "cefa_params.svh"

module ctrl_endpoint_fifo_access_bench;
  localparam logic [7:0] sel_a = `CEFA_SEL_ADDR;
  localparam logic [7:0] ctl_a = `CEFA_CTL_ADDR;
  logic        MCLK, RSTN, WIDTH_SELECT_PIN;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, S_AXI_RREADY;
  logic        SETUP_RX, RX_DONE, TX_WR_DONE, TX_DONE, BUF_BUSY, DPORT_RD;
  logic [8:0]  RX_LEN;
  logic [15:0] BUF_WORD, DPORT_WORD;
  logic        DIR_SEL, PORT_8BIT, FORCE_SHORT, CLR_CPU_BUF, CLR_SIE_BUF;
  logic [2:0]  DATA_ANSWER, STATUS_ANSWER;
  int          error_cnt, checked, n_fs, n_cc, n_cs;

  cefa_top       u_dut (.*);
  cefa_sie_model u_sie (.*);

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  always @(posedge MCLK) begin
    n_fs += FORCE_SHORT;
    n_cc += CLR_CPU_BUF;
    n_cs += CLR_SIE_BUF;
  end

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {16'h0000, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    forever begin
      @(posedge MCLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    S_AXI_BREADY <= 1'b0;
    chk({S_AXI_BVALID, S_AXI_BRESP}, {1'b1, `CEFA_RESP_OKAY});
    // One idle edge so the next call never reassigns a ready in this step
    @(posedge MCLK);
  endtask

  // Expected value carries the response code in bits 17:16
  task automatic rc(input logic [7:0] a, input logic [17:0] e);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    forever begin
      @(posedge MCLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    S_AXI_RREADY <= 1'b0;
    chk({S_AXI_RVALID, S_AXI_RRESP, S_AXI_RDATA}, {1'b1, e[17:16], 16'h0000, e[15:0]});
    @(posedge MCLK);
  endtask

  task automatic final_report;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    error_cnt++;
    final_report;
  end

  initial begin
    {RSTN, WIDTH_SELECT_PIN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 5'h00;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = 18'h00000;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'h3;
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    rc(sel_a, 18'h00000);
    rc(ctl_a, 18'h00800);
    u_sie.levels(1'b0, 16'hA55A);
    repeat (2) @(posedge MCLK);
    rc(ctl_a, 18'h00000);
    rc(8'h10, 18'h20000);
    for (int k = 0; k < 4; k++) begin
      wr(ctl_a, {k[1:0], 14'h0400});
      rc(ctl_a, {2'h0, k[1:0], 14'h0400});
      chk({DATA_ANSWER, STATUS_ANSWER}, {2{3'h1 << (k > 1 ? 2 : k)}});
    end
    wr(ctl_a, 16'h4000);
    repeat (2) @(posedge MCLK);
    chk({DATA_ANSWER, STATUS_ANSWER}, 6'h11);
    wr(ctl_a, 16'h4400);
    u_sie.pulse(0, 9'h000);
    rc(ctl_a, 18'h00000);
    u_sie.pulse(1, 9'h005);
    rc(ctl_a, 18'h02005);
    repeat (2) u_sie.pulse(4, 9'h000);
    rc(ctl_a, 18'h02005);
    u_sie.pulse(4, 9'h000);
    rc(ctl_a, 18'h00000);
    wr(sel_a, 16'h8400);
    u_sie.pulse(1, 9'h004);
    u_sie.pulse(4, 9'h000);
    rc(ctl_a, 18'h02003);
    wr(ctl_a, 16'h1000);
    rc(ctl_a, 18'h00000);
    wr(ctl_a, 16'h2000);
    rc(ctl_a, 18'h00000);
    wr(sel_a, 16'h8000);
    u_sie.pulse(1, 9'h006);
    u_sie.pulse(4, 9'h000);
    rc(ctl_a, 18'h02004);
    wr(sel_a, 16'h0000);
    repeat (2) @(posedge MCLK);
    chk(DPORT_WORD, 16'hA55A);
    wr(sel_a, 16'h0080);
    repeat (2) @(posedge MCLK);
    chk(DPORT_WORD, 16'h5AA5);
    wr(sel_a, 16'h0400);
    repeat (2) @(posedge MCLK);
    chk({PORT_8BIT, DPORT_WORD}, 17'h1005A);
    WIDTH_SELECT_PIN <= 1'b1;
    repeat (3) @(posedge MCLK);
    rc(sel_a, 18'h00000);
    wr(sel_a, 16'h0000);
    repeat (2) @(posedge MCLK);
    chk({PORT_8BIT, DPORT_WORD}, 17'h1005A);
    WIDTH_SELECT_PIN <= 1'b0;
    // Drain the write buffer so the read direction starts empty
    repeat (2) u_sie.pulse(4, 9'h000);
    rc(ctl_a, 18'h00000);
    wr(sel_a, 16'h0001);
    repeat (2) @(posedge MCLK);
    chk(DIR_SEL, 1'b1);
    u_sie.pulse(2, 9'h000);
    rc(ctl_a, 18'h02000);
    wr(ctl_a, 16'h0000);
    rc(ctl_a, 18'h02000);
    wr(ctl_a, 16'h1000);
    rc(ctl_a, 18'h00000);
    wr(ctl_a, 16'h1000);
    rc(ctl_a, 18'h00000);
    chk({n_cs[7:0], n_cc[7:0]}, 16'h0102);
    wr(ctl_a, 16'h3000);
    rc(ctl_a, 18'h02000);
    chk(n_fs, 34'h1);
    u_sie.pulse(3, 9'h000);
    rc(ctl_a, 18'h00000);
    final_report;
  end
endmodule // ctrl_endpoint_fifo_access_bench
